// ### rtl/rcl_pkg.sv
// Constants, enumerations and carriers shared by the reset-cause logic.
// Assumes one 10 MHz system clock and a 16-bit register port.
package rcl_pkg;
   localparam int unsigned ADDR_W = 4;
   localparam int unsigned DATA_W = 16;
   localparam int unsigned PPS_COUNT = 4;
   localparam int unsigned PPS_W = 16;
   localparam int unsigned WREG_COUNT = 16;
   localparam int unsigned WREG_SP = 15;
   // Register offsets
   localparam logic [ADDR_W-1:0] OFS_RESET_CTRL = 4'h0;
   localparam logic [ADDR_W-1:0] OFS_SEC_LO = 4'h1;
   localparam logic [ADDR_W-1:0] OFS_SEC_HI = 4'h2;
   localparam logic [ADDR_W-1:0] OFS_MODE_STATUS = 4'h3;
   // reset_control_register bit positions
   localparam int unsigned BIT_TRAP = 15;
   localparam int unsigned BIT_ILLEGAL = 14;
   localparam int unsigned BIT_CM = 9;
   localparam int unsigned BIT_EXTERNAL_PIN_RESET_FLAG = 7;
   localparam int unsigned BIT_SWR = 6;
   localparam int unsigned BIT_WATCHDOG_TIMEOUT_FLAG = 4;
   localparam int unsigned BIT_SLEEP = 3;
   localparam int unsigned BIT_IDLE = 2;
   localparam int unsigned BIT_BOR = 1;
   localparam int unsigned BIT_POR = 0;
   localparam logic [DATA_W-1:0] RESET_CAUSE_STATUS_IMPL_MASK = 16'hc2df;
   localparam logic [DATA_W-1:0] RESET_CAUSE_STATUS_POR_VAL = 16'h0003;
   localparam logic [DATA_W-1:0] SEC_LO_RST = 16'hffff;
   localparam logic [DATA_W-1:0] SEC_HI_RST = 16'h0000;
   localparam logic [7:0] ILLEGAL_OPC_BYTE = 8'h3f;
   localparam logic [3:0] HARD_TRAP_MIN = 4'hd;
   localparam logic [3:0] HARD_TRAP_MAX = 4'hf;
   localparam logic [1:0] RST_HOLD_CYC = 2'h2;
   localparam logic [1:0] SYNC_RST_VAL = 2'h1;

   typedef enum logic [1:0] {
      MODE_RUN = 2'h0,
      MODE_IDLE = 2'h1,
      MODE_SLEEP = 2'h3
   } rcl_mode_t;

   typedef enum logic [2:0] {
      OP_NONE = 3'h0,
      OP_CALL = 3'h1,
      OP_JUMP = 3'h2,
      OP_CJUMP = 3'h3,
      OP_RETURN = 3'h4,
      OP_RETSUB = 3'h5,
      OP_BRANCH = 3'h6
   } rcl_flow_op_t;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } rcl_bus_req_t;

   typedef struct packed {
      logic valid;
      logic is_vector;
      rcl_flow_op_t op;
      logic src_inside;
      logic [23:0] target;
   } rcl_flow_t;

   typedef struct packed {
      logic valid;
      logic [3:0] level;
   } rcl_trap_t;
endpackage

// ### rtl/rcl_sync.sv
// Three-stage synchroniser with an agreement filter for pin levels.
// Assumes inputs are asynchronous to clk; output changes only when
// stages two and three agree.
`timescale 1ns/1ps
`default_nettype none
module rcl_sync
   import rcl_pkg::*;
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic [1:0] async_in,
   output logic [1:0] level_q
);
   logic [1:0] s1_q;
   logic [1:0] s2_q;
   logic [1:0] s3_q;

   always_ff @(posedge clk) begin
      if (!resetn) begin
         s1_q <= SYNC_RST_VAL;
         s2_q <= SYNC_RST_VAL;
         s3_q <= SYNC_RST_VAL;
      end else begin
         s1_q <= async_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // Keep old level while the last two stages disagree
   always_ff @(posedge clk) begin
      if (!resetn) begin
         level_q <= SYNC_RST_VAL;
      end else begin
         level_q <= (s2_q & s3_q) | (level_q & (s2_q ^ s3_q));
      end
   end
endmodule
`default_nettype wire

// ### rtl/rcl_wreg_track.sv
// Tracks which working registers hold a written value since reset.
// Assumes the core reports each register write and each pointer use.
`timescale 1ns/1ps
`default_nettype none
module rcl_wreg_track
   import rcl_pkg::*;
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic sys_rst,
   input wire logic wr_en,
   input wire logic [3:0] wr_idx,
   input wire logic ptr_use,
   input wire logic [3:0] ptr_idx,
   output logic [WREG_COUNT-1:0] init_q,
   output logic uninit_hit
);
   genvar g;
   generate
      for (g = 0; g < WREG_COUNT; g++) begin : g_wreg
         if (g == WREG_SP) begin : g_sp
            // Stack pointer is never cleared
            always_ff @(posedge clk) begin
               init_q[g] <= 1'b1;
            end
         end else begin : g_w
            always_ff @(posedge clk) begin
               if (!resetn || sys_rst) begin
                  init_q[g] <= 1'b0;
               end else if (wr_en && wr_idx == 4'(g)) begin
                  init_q[g] <= 1'b1;
               end
            end
         end
      end
   endgenerate

   assign uninit_hit = ptr_use & ~init_q[ptr_idx];
endmodule
`default_nettype wire

// ### rtl/rcl_top.sv
// Reset-cause logic: gathers reset sources, drives the system reset and
// keeps the reset control register. Assumes core event inputs are on clk
// and the master clear and brown-out inputs are asynchronous levels.
//
// Overview of operation
// - Watchdog in run: async reset, keep clock
// - Watchdog in sleep or idle: wake only
// - Watchdog reset sets flag bit 4
// - Lower hard trap during higher trap resets
// - Trap conflict sets bit 15, power clears
// - Pin select registers checked against shadows
// - Mismatch sets bit 9, feature optional
// - Upper byte 3Fh opcode resets device
// - Uninitialised working register pointer resets
// - Reset clears working registers except 15
// - Restricted secure target flow change resets
// - Branch style PC reloads are program flow
// - Vector PC reloads are vector flow
// - Illegal conditions set flag bit 14
// - Power save, clear, power events clear flag
// - Software may set or clear flags
// - Power-on sets flag bit 0
// - Brown-out sets flag bit 1
// - Reset instruction sets flag bit 6
`timescale 1ns/1ps
`default_nettype none
module rcl_top
   import rcl_pkg::*;
#(
   parameter bit CM_PRESENT = 1'b1
)
(
   input wire logic clk,
   input wire logic resetn,
   input wire rcl_bus_req_t bus_req,
   output logic [DATA_W-1:0] rd_data_q,
   input wire logic master_clear_pin_n,
   input wire logic brownout_reset,
   input wire logic wdt_timeout,
   input wire logic wake_event,
   input wire logic power_save_instruction,
   input wire logic power_save_sleep,
   input wire logic watchdog_clear_instruction,
   input wire logic reset_instruction,
   input wire rcl_trap_t trap_req,
   input wire rcl_trap_t trap_active,
   input wire logic [PPS_COUNT-1:0][PPS_W-1:0] pps_live,
   input wire logic pps_wr,
   input wire logic [1:0] pps_wr_idx,
   input wire logic [PPS_W-1:0] pps_wr_data,
   input wire logic instr_valid,
   input wire logic [23:0] instr_word,
   input wire logic wreg_wr,
   input wire logic [3:0] wreg_wr_idx,
   input wire logic ptr_use,
   input wire logic [3:0] ptr_idx,
   input wire rcl_flow_t flow,
   output logic system_reset_q,
   output logic wake_q,
   output logic clk_reselect_q,
   output rcl_mode_t mode_q,
   output logic [WREG_COUNT-1:0] wreg_init_q
);
   localparam logic [DATA_W-1:0] RESET_CAUSE_STATUS_MASK =
      CM_PRESENT ? RESET_CAUSE_STATUS_IMPL_MASK : (RESET_CAUSE_STATUS_IMPL_MASK & ~(16'h0001 << BIT_CM));
   localparam logic [DATA_W-1:0] RESET_CAUSE_STATUS_POWER_KEEP =
      (16'h0001 << BIT_POR) | (16'h0001 << BIT_EXTERNAL_PIN_RESET_FLAG);

   logic [1:0] pin_lvl;
   logic bor_lvl;
   logic external_pin_reset_flag;
   logic cpu_ok;
   logic wdt_run;
   logic wdt_async_set;
   logic trap_conf;
   logic illegal_opc;
   logic uninit_hit;
   logic program_flow_change;
   logic vector_flow_change;
   logic restricted;
   logic sec_err;
   logic software_reset_flag;
   logic cm_err;
   logic [PPS_COUNT-1:0] pps_miss;
   logic rst_src;
   logic [1:0] hold_q;
   logic [DATA_W-1:0] reset_cause_status_q;
   logic [DATA_W-1:0] reset_cause_status_d;
   logic [DATA_W-1:0] reset_cause_status_set;
   logic reset_cause_status_clr;
   logic [DATA_W-1:0] sec_lo_q;
   logic [DATA_W-1:0] sec_hi_q;
   logic [PPS_W-1:0] shadow_q [PPS_COUNT];
   logic wr_reset_cause_status;

   rcl_sync u_sync (
      .clk(clk),
      .resetn(resetn),
      .async_in({brownout_reset, master_clear_pin_n}),
      .level_q(pin_lvl)
   );

   assign bor_lvl = pin_lvl[1];
   assign external_pin_reset_flag = ~pin_lvl[0];
   // Core events are ignored while the core is held in reset
   assign cpu_ok = ~system_reset_q;

   assign wdt_run = wdt_timeout & (mode_q == MODE_RUN);
   assign wdt_async_set = wdt_run;

   assign trap_conf = cpu_ok & trap_req.valid & trap_active.valid
      & (trap_req.level >= HARD_TRAP_MIN) & (trap_req.level <= HARD_TRAP_MAX)
      & (trap_active.level > trap_req.level);

   assign illegal_opc = cpu_ok & instr_valid & (instr_word[23:16] == ILLEGAL_OPC_BYTE);

   rcl_wreg_track u_wreg (
      .clk(clk),
      .resetn(resetn),
      .sys_rst(system_reset_q),
      .wr_en(wreg_wr),
      .wr_idx(wreg_wr_idx),
      .ptr_use(ptr_use & cpu_ok),
      .ptr_idx(ptr_idx),
      .init_q(wreg_init_q),
      .uninit_hit(uninit_hit)
   );

   assign program_flow_change = flow.valid & ~flow.is_vector & (flow.op != OP_NONE);
   assign vector_flow_change = flow.valid & flow.is_vector;
   assign restricted = (flow.target[23:8] >= sec_lo_q) & (flow.target[23:8] <= sec_hi_q)
      & ~flow.src_inside;
   assign sec_err = cpu_ok & (program_flow_change | vector_flow_change) & restricted;

   assign software_reset_flag = cpu_ok & reset_instruction;

   // Shadow copies of pin select registers
   genvar g;
   generate
      for (g = 0; g < PPS_COUNT; g++) begin : g_pps
         always_ff @(posedge clk) begin
            if (!resetn) begin
               shadow_q[g] <= '0;
            end else if (pps_wr && pps_wr_idx == 2'(g)) begin
               shadow_q[g] <= pps_wr_data;
            end
         end
         assign pps_miss[g] = (pps_live[g] != shadow_q[g]);
      end
   endgenerate

   assign cm_err = CM_PRESENT & (|pps_miss);

   assign rst_src = trap_conf | illegal_opc | uninit_hit | sec_err | software_reset_flag | external_pin_reset_flag
      | bor_lvl | cm_err | wdt_run;

   always_ff @(posedge clk or posedge wdt_async_set) begin
      if (wdt_async_set) begin
         system_reset_q <= 1'b1;
      end else if (!resetn || rst_src) begin
         system_reset_q <= 1'b1;
      end else if (hold_q == 2'h0) begin
         system_reset_q <= 1'b0;
      end
   end

   // Minimum hold after the last source
   always_ff @(posedge clk) begin
      if (!resetn || rst_src) begin
         hold_q <= RST_HOLD_CYC;
      end else if (hold_q != 2'h0) begin
         hold_q <= hold_q - 2'h1;
      end
   end

   always_ff @(posedge clk) begin
      clk_reselect_q <= ~resetn | bor_lvl;
   end

   // Power mode state
   always_ff @(posedge clk) begin
      if (!resetn || system_reset_q) begin
         mode_q <= MODE_RUN;
      end else begin
         case (mode_q)
            MODE_RUN: begin
               if (power_save_instruction) begin
                  mode_q <= power_save_sleep ? MODE_SLEEP : MODE_IDLE;
               end
            end
            MODE_IDLE, MODE_SLEEP: begin
               if (wdt_timeout || wake_event) begin
                  mode_q <= MODE_RUN;
               end
            end
            default: begin
               mode_q <= MODE_RUN;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         wake_q <= 1'b0;
      end else begin
         wake_q <= wdt_timeout & (mode_q != MODE_RUN);
      end
   end

   assign wr_reset_cause_status = bus_req.wr & (bus_req.addr == OFS_RESET_CTRL);
   assign reset_cause_status_clr = cpu_ok & (power_save_instruction | watchdog_clear_instruction);

   always_comb begin
      reset_cause_status_set = '0;
      reset_cause_status_set[BIT_WATCHDOG_TIMEOUT_FLAG] = wdt_run;
      reset_cause_status_set[BIT_TRAP] = trap_conf;
      reset_cause_status_set[BIT_ILLEGAL] = illegal_opc | uninit_hit | sec_err;
      reset_cause_status_set[BIT_CM] = cm_err;
      reset_cause_status_set[BIT_EXTERNAL_PIN_RESET_FLAG] = external_pin_reset_flag;
      reset_cause_status_set[BIT_SWR] = software_reset_flag;
      reset_cause_status_set[BIT_SLEEP] = cpu_ok & power_save_instruction & power_save_sleep;
      reset_cause_status_set[BIT_IDLE] = cpu_ok & power_save_instruction & ~power_save_sleep;
      reset_cause_status_set[BIT_BOR] = bor_lvl;
   end

   always_comb begin
      reset_cause_status_d = reset_cause_status_q;
      if (bor_lvl) begin
         reset_cause_status_d = reset_cause_status_q & RESET_CAUSE_STATUS_POWER_KEEP;
      end
      if (wr_reset_cause_status) begin
         reset_cause_status_d = bus_req.wdata & RESET_CAUSE_STATUS_MASK;
      end
      if (reset_cause_status_clr) begin
         reset_cause_status_d[BIT_WATCHDOG_TIMEOUT_FLAG] = 1'b0;
      end
      // Hardware set wins over any clear
      reset_cause_status_d = reset_cause_status_d | (reset_cause_status_set & RESET_CAUSE_STATUS_MASK);
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         reset_cause_status_q <= RESET_CAUSE_STATUS_POR_VAL;
      end else begin
         reset_cause_status_q <= reset_cause_status_d;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         sec_lo_q <= SEC_LO_RST;
         sec_hi_q <= SEC_HI_RST;
      end else if (bus_req.wr) begin
         if (bus_req.addr == OFS_SEC_LO) begin
            sec_lo_q <= bus_req.wdata;
         end
         if (bus_req.addr == OFS_SEC_HI) begin
            sec_hi_q <= bus_req.wdata;
         end
      end
   end

   // Read data valid only the cycle after the strobe
   always_ff @(posedge clk) begin
      if (!resetn || !bus_req.rd) begin
         rd_data_q <= '0;
      end else begin
         case (bus_req.addr)
            OFS_RESET_CTRL: rd_data_q <= reset_cause_status_q;
            OFS_SEC_LO: rd_data_q <= sec_lo_q;
            OFS_SEC_HI: rd_data_q <= sec_hi_q;
            OFS_MODE_STATUS: rd_data_q <= {13'h0, system_reset_q, mode_q};
            default: rd_data_q <= '0;
         endcase
      end
   end

   // Checks
   AST_WDT_ASYNC: assert property (@(posedge clk) disable iff (!resetn)
      wdt_run |=> system_reset_q && reset_cause_status_q[BIT_WATCHDOG_TIMEOUT_FLAG])
      else $error("watchdog in run did not reset");
   AST_WDT_CLK_KEEP: assert property (@(posedge clk) disable iff (!resetn)
      (wdt_run && !bor_lvl) |=> !clk_reselect_q)
      else $error("watchdog reset reselected clock");
   AST_WDT_WAKE: assert property (@(posedge clk) disable iff (!resetn)
      (wdt_timeout && mode_q != MODE_RUN && !system_reset_q && !(rst_src && !wdt_run))
      |=> wake_q && !system_reset_q && mode_q == MODE_RUN)
      else $error("watchdog in power save reset or failed to wake");
   AST_WATCHDOG_TIMEOUT_FLAG_FLAG: assert property (@(posedge clk) disable iff (!resetn)
      $rose(reset_cause_status_q[BIT_WATCHDOG_TIMEOUT_FLAG]) |-> $past(wdt_run) || $past(wr_reset_cause_status))
      else $error("watchdog flag set without cause");
   AST_TRAP_RST: assert property (@(posedge clk) disable iff (!resetn)
      trap_conf |=> system_reset_q ##1 system_reset_q)
      else $error("trap conflict did not reset");
   AST_TRAP_FLAG: assert property (@(posedge clk) disable iff (!resetn)
      (reset_cause_status_q[BIT_TRAP] && !bor_lvl && !wr_reset_cause_status) |=> reset_cause_status_q[BIT_TRAP])
      else $error("trap flag lost");
   AST_CM_RST: assert property (@(posedge clk) disable iff (!resetn)
      (cm_err && !bor_lvl) |=> system_reset_q && reset_cause_status_q[BIT_CM])
      else $error("mismatch not reported");
   AST_ILLEGAL_OPC: assert property (@(posedge clk) disable iff (!resetn)
      (cpu_ok && instr_valid && instr_word[23:16] == ILLEGAL_OPC_BYTE && !bor_lvl)
      |=> system_reset_q && reset_cause_status_q[BIT_ILLEGAL])
      else $error("illegal opcode not reset");
   AST_UNINIT: assert property (@(posedge clk) disable iff (!resetn)
      (cpu_ok && ptr_use && !wreg_init_q[ptr_idx] && !bor_lvl)
      |=> system_reset_q && reset_cause_status_q[BIT_ILLEGAL])
      else $error("uninitialised pointer not reset");
   AST_WREG_CLEAR: assert property (@(posedge clk) disable iff (!resetn)
      $fell(system_reset_q) |-> wreg_init_q == 16'h8000)
      else $error("working registers not cleared");
   AST_SEC_RST: assert property (@(posedge clk) disable iff (!resetn)
      (sec_err && !bor_lvl) |=> system_reset_q && reset_cause_status_q[BIT_ILLEGAL])
      else $error("security violation not reset");
   AST_WATCHDOG_TIMEOUT_FLAG_CLR: assert property (@(posedge clk) disable iff (!resetn)
      (reset_cause_status_clr && !wdt_run) |=> !reset_cause_status_q[BIT_WATCHDOG_TIMEOUT_FLAG])
      else $error("watchdog flag not cleared");
   AST_SW_WRITE: assert property (@(posedge clk) disable iff (!resetn)
      (wr_reset_cause_status && reset_cause_status_set == '0 && !reset_cause_status_clr && !bor_lvl)
      |=> reset_cause_status_q == ($past(bus_req.wdata) & RESET_CAUSE_STATUS_MASK))
      else $error("software write not stored");
   AST_POR_FLAGS: assert property (@(posedge clk) disable iff (!resetn)
      $rose(resetn) |-> reset_cause_status_q[BIT_POR] && reset_cause_status_q[BIT_BOR])
      else $error("power-on flags missing");
   AST_SWR: assert property (@(posedge clk) disable iff (!resetn)
      (software_reset_flag && !bor_lvl) |=> system_reset_q && reset_cause_status_q[BIT_SWR])
      else $error("reset instruction not reported");
   AST_HOLD: assert property (@(posedge clk) disable iff (!resetn)
      $rose(system_reset_q) |-> system_reset_q[*3])
      else $error("system reset too short");

   COV_WDT_RST: cover property (@(posedge clk) disable iff (!resetn) wdt_run);
   COV_WAKE: cover property (@(posedge clk) disable iff (!resetn) $rose(wake_q));
   COV_TRAP: cover property (@(posedge clk) disable iff (!resetn) trap_conf);
   COV_SEC: cover property (@(posedge clk) disable iff (!resetn) sec_err && vector_flow_change);
endmodule
`default_nettype wire

// ### verif/tb_reset_cause_logic.sv
// Self-checking bench for the reset-cause logic top module.
// Assumes the bench alone drives every port; one 10 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module tb_reset_cause_logic;
   import rcl_pkg::*;
   logic clk, resetn, pin_n, bor, wdt, wake_ev, ps, ps_sleep, wdt_clr, rst_ins;
   logic pps_wr, instr_valid, wreg_wr, ptr_use;
   logic system_reset_q, wake_q, clk_reselect_q;
   logic [1:0] pps_wr_idx;
   logic [3:0] wreg_wr_idx, ptr_idx;
   logic [15:0] pps_wr_data, rd_data_q, wreg_init_q, d;
   logic [23:0] instr_word;
   logic [PPS_COUNT-1:0][PPS_W-1:0] pps_live;
   rcl_bus_req_t bus_req;
   rcl_trap_t trap_req, trap_active;
   rcl_flow_t flow;
   rcl_mode_t mode_q;
   int error_cnt = 0;
   int comparisons = 0;

   rcl_top uut (.clk(clk), .resetn(resetn), .bus_req(bus_req), .rd_data_q(rd_data_q),
      .master_clear_pin_n(pin_n), .brownout_reset(bor), .wdt_timeout(wdt),
      .wake_event(wake_ev), .power_save_instruction(ps), .power_save_sleep(ps_sleep),
      .watchdog_clear_instruction(wdt_clr), .reset_instruction(rst_ins),
      .trap_req(trap_req), .trap_active(trap_active), .pps_live(pps_live),
      .pps_wr(pps_wr), .pps_wr_idx(pps_wr_idx), .pps_wr_data(pps_wr_data),
      .instr_valid(instr_valid), .instr_word(instr_word), .wreg_wr(wreg_wr),
      .wreg_wr_idx(wreg_wr_idx), .ptr_use(ptr_use), .ptr_idx(ptr_idx), .flow(flow),
      .system_reset_q(system_reset_q), .wake_q(wake_q),
      .clk_reselect_q(clk_reselect_q), .mode_q(mode_q), .wreg_init_q(wreg_init_q));

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   task automatic complete_run;
      if (error_cnt == 0 && comparisons > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic chk(string n, logic [15:0] e, logic [15:0] g);
      comparisons++;
      if (g !== e) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic chkb(string n, logic e, logic g);
      chk(n, {15'h0, e}, {15'h0, g});
   endtask

   task automatic wr(logic [3:0] a, logic [15:0] v);
      @(posedge clk);
      bus_req <= '{1'b1, 1'b0, a, v};
      @(posedge clk);
      bus_req <= '0;
   endtask

   task automatic rd(logic [3:0] a, output logic [15:0] v);
      @(posedge clk);
      bus_req <= '{1'b0, 1'b1, a, 16'h0};
      @(posedge clk);
      bus_req <= '0;
      #1 v = rd_data_q;
   endtask

   task automatic wait_rel;
      int i;
      i = 0;
      while (system_reset_q !== 1'b0 && i < 20) begin
         @(posedge clk);
         #1 i++;
      end
      chkb("sys_release", 1'b0, system_reset_q);
   endtask

   // Reset must be up now, then release, flag kept, flags cleared after
   task automatic expect_rst(int b);
      chkb("sys_rst", 1'b1, system_reset_q);
      wait_rel;
      rd(OFS_RESET_CTRL, d);
      chkb("cause_flag", 1'b1, d[b]);
      wr(OFS_RESET_CTRL, 16'h0);
   endtask

   task automatic no_rst;
      chkb("no_rst", 1'b0, system_reset_q);
      @(posedge clk);
      #1 chkb("no_rst", 1'b0, system_reset_q);
   endtask

   task automatic t_reset_vals;
      rd(OFS_RESET_CTRL, d);
      chk("reset_cause_status_rst", 16'h0003, d);
      rd(OFS_SEC_LO, d);
      chk("sec_lo", 16'hffff, d);
      rd(OFS_SEC_HI, d);
      chk("sec_hi", 16'h0000, d);
      rd(4'h9, d);
      chk("unmapped", 16'h0000, d);
      chk("wreg_init", 16'h8000, wreg_init_q);
      wr(OFS_RESET_CTRL, 16'h0);
   endtask

   task automatic t_sw_rw;
      wr(OFS_RESET_CTRL, 16'hffff);
      rd(OFS_RESET_CTRL, d);
      chk("reset_cause_status_set", RESET_CAUSE_STATUS_IMPL_MASK, d);
      wr(OFS_RESET_CTRL, 16'h0);
      rd(OFS_RESET_CTRL, d);
      chk("reset_cause_status_clr", 16'h0000, d);
      wr(OFS_MODE_STATUS, 16'hffff);
      rd(OFS_MODE_STATUS, d);
      chk("status_ro", 16'h0000, d);
   endtask

   task automatic t_swr;
      @(posedge clk);
      wreg_wr <= 1'b1;
      wreg_wr_idx <= 4'h2;
      @(posedge clk);
      wreg_wr <= 1'b0;
      rst_ins <= 1'b1;
      @(posedge clk);
      rst_ins <= 1'b0;
      #1 chkb("swr_rst", 1'b1, system_reset_q);
      repeat (2) begin
         @(posedge clk);
         #1 chkb("swr_hold", 1'b1, system_reset_q);
      end
      @(posedge clk);
      #1 chkb("swr_release", 1'b0, system_reset_q);
      chkb("swr_clk", 1'b0, clk_reselect_q);
      chk("wreg_cleared", 16'h8000, wreg_init_q);
      rd(OFS_RESET_CTRL, d);
      chkb("swr_flag", 1'b1, d[BIT_SWR]);
      wr(OFS_RESET_CTRL, 16'h0);
   endtask

   task automatic t_wdt_run;
      @(posedge clk);
      wdt <= 1'b1;
      #1 chkb("wdt_async", 1'b1, system_reset_q);
      chkb("wdt_clk", 1'b0, clk_reselect_q);
      @(posedge clk);
      wdt <= 1'b0;
      #1 expect_rst(BIT_WATCHDOG_TIMEOUT_FLAG);
      wr(OFS_RESET_CTRL, 16'h0010);
      @(posedge clk);
      wdt_clr <= 1'b1;
      @(posedge clk);
      wdt_clr <= 1'b0;
      rd(OFS_RESET_CTRL, d);
      chk("wdt_clr", 16'h0000, d);
   endtask

   task automatic t_wdt_save(logic s);
      wr(OFS_RESET_CTRL, 16'h0010);
      @(posedge clk);
      ps <= 1'b1;
      ps_sleep <= s;
      @(posedge clk);
      ps <= 1'b0;
      #1 chk("mode", {14'h0, s, 1'b1}, {14'h0, mode_q});
      rd(OFS_RESET_CTRL, d);
      chk("ps_flags", s ? 16'h0008 : 16'h0004, d);
      @(posedge clk);
      wdt <= 1'b1;
      @(posedge clk);
      wdt <= 1'b0;
      #1 chkb("wake", 1'b1, wake_q);
      chkb("wake_no_rst", 1'b0, system_reset_q);
      chk("wake_mode", 16'h0, {14'h0, mode_q});
      @(posedge clk);
      #1 chkb("wake_pulse", 1'b0, wake_q);
      rd(OFS_RESET_CTRL, d);
      chkb("wake_no_watchdog_timeout_flag", 1'b0, d[BIT_WATCHDOG_TIMEOUT_FLAG]);
      wr(OFS_RESET_CTRL, 16'h0);
   endtask

   task automatic trap(logic [3:0] act, logic [3:0] req, logic hit);
      @(posedge clk);
      trap_active <= '{1'b1, act};
      trap_req <= '{1'b1, req};
      @(posedge clk);
      trap_active <= '0;
      trap_req <= '0;
      #1;
      if (hit) begin
         expect_rst(BIT_TRAP);
      end else begin
         no_rst;
      end
   endtask

   task automatic opc(logic [23:0] w, logic hit);
      @(posedge clk);
      instr_valid <= 1'b1;
      instr_word <= w;
      @(posedge clk);
      instr_valid <= 1'b0;
      #1;
      if (hit) begin
         expect_rst(BIT_ILLEGAL);
      end else begin
         no_rst;
      end
   endtask

   task automatic ptr(logic [3:0] i, logic hit);
      @(posedge clk);
      ptr_use <= 1'b1;
      ptr_idx <= i;
      @(posedge clk);
      ptr_use <= 1'b0;
      #1;
      if (hit) begin
         expect_rst(BIT_ILLEGAL);
      end else begin
         no_rst;
      end
   endtask

   task automatic t_uninit;
      ptr(4'h3, 1'b1);
      @(posedge clk);
      wreg_wr <= 1'b1;
      wreg_wr_idx <= 4'h3;
      @(posedge clk);
      wreg_wr <= 1'b0;
      #1 chk("wreg_mark", 16'h8008, wreg_init_q);
      ptr(4'h3, 1'b0);
      ptr(4'hf, 1'b0);
   endtask

   task automatic sec(rcl_flow_t f, logic hit);
      wr(OFS_SEC_LO, 16'h0010);
      wr(OFS_SEC_HI, 16'h0020);
      @(posedge clk);
      flow <= f;
      @(posedge clk);
      flow <= '0;
      #1;
      if (hit) begin
         expect_rst(BIT_ILLEGAL);
      end else begin
         no_rst;
      end
   endtask

   task automatic t_cm;
      @(posedge clk);
      pps_wr <= 1'b1;
      pps_wr_idx <= 2'h0;
      pps_wr_data <= 16'h1234;
      @(posedge clk);
      pps_wr <= 1'b0;
      pps_live[0] <= 16'h1234;
      @(posedge clk);
      #1 no_rst;
      @(posedge clk);
      pps_live[0] <= 16'h1235;
      @(posedge clk);
      pps_live[0] <= 16'h1234;
      #1 expect_rst(BIT_CM);
   endtask

   task automatic t_pin_bor;
      @(posedge clk);
      pin_n <= 1'b0;
      repeat (6) @(posedge clk);
      pin_n <= 1'b1;
      #1 chkb("pin_rst", 1'b1, system_reset_q);
      wait_rel;
      rd(OFS_RESET_CTRL, d);
      chk("pin_flag", 16'h0080, d);
      wr(OFS_RESET_CTRL, 16'h82d0);
      @(posedge clk);
      bor <= 1'b1;
      repeat (6) @(posedge clk);
      #1 chkb("bor_rst", 1'b1, system_reset_q);
      chkb("bor_clk", 1'b1, clk_reselect_q);
      @(posedge clk);
      bor <= 1'b0;
      wait_rel;
      rd(OFS_RESET_CTRL, d);
      chk("bor_flags", 16'h0082, d);
      wr(OFS_RESET_CTRL, 16'h0);
   endtask

   initial begin
      repeat (5000) @(posedge clk);
      error_cnt++;
      complete_run;
   end

   initial begin
      resetn = 1'b0;
      pin_n = 1'b1;
      {bor, wdt, wake_ev, ps, ps_sleep, wdt_clr, rst_ins} = '0;
      {pps_wr, instr_valid, wreg_wr, ptr_use} = '0;
      {pps_wr_idx, wreg_wr_idx, ptr_idx, pps_wr_data, instr_word} = '0;
      pps_live = '0;
      bus_req = '0;
      trap_req = '0;
      trap_active = '0;
      flow = '0;
      repeat (12) @(posedge clk);
      resetn <= 1'b1;
      wait_rel;
      t_reset_vals;
      t_sw_rw;
      t_swr;
      t_wdt_run;
      t_wdt_save(1'b1);
      t_wdt_save(1'b0);
      trap(4'he, 4'hd, 1'b1);
      trap(4'hd, 4'he, 1'b0);
      trap(4'he, 4'hc, 1'b0);
      opc(24'h3f0000, 1'b1);
      opc(24'h3e0000, 1'b0);
      t_uninit;
      for (int i = 1; i < 7; i++) begin
         sec('{1'b1, 1'b0, rcl_flow_op_t'(i), 1'b0, 24'h001500}, 1'b1);
      end
      sec('{1'b1, 1'b1, OP_NONE, 1'b0, 24'h001000}, 1'b1);
      sec('{1'b1, 1'b0, OP_CALL, 1'b1, 24'h001500}, 1'b0);
      sec('{1'b1, 1'b0, OP_JUMP, 1'b0, 24'h002100}, 1'b0);
      t_cm;
      t_pin_bor;
      complete_run;
   end
endmodule
`default_nettype wire
